// ### rtl/audio_input_oversampling_path.sv
// Audio serial input, word-select lock, volume and oversampling path with APB registers.
//
// Functional notes
// - Eight-bit volume code selects gain.
// - Four-bit fade code sets fade duration; in double speed the volume jumps to the target at once.
// - Mute bit one engages soft mute.
// - Run-fade bit applies new volume settings.
// - Four-bit overload threshold in 3 dB steps.
// - Silence level and duration codes.
// - Analyser tap before or after tone.
// - Speed bit one selects double speed.
// - Clear-memory write flushes delay line.
// - Reserved bits stored without function.
// - Format field selects serial input format.
// - Only eighteen bits reach the audio.
// - Left transitions checked, else lock lost.
// - Hunt in repeated 16-clock windows.
// - Locked transitions accepted in 32-clock window.
// - Normal speed uses orders 75, 11, 7.
// - Linear to 16x, hold six times.
// - Double speed: 51, 7, linear, hold.
// - Format, speed, clear in extended zero.
// - Main store is sixteen nibble registers.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "audio_consts.svh"

module audio_input_oversampling_path (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 bck_in,
	input  wire logic                 ws_in,
	input  wire logic                 data_in,
	output audio_pkg::stereo_s        os_data,
	output logic                      os_strobe,
	output logic                      lock_ok,
	output logic      [17:0]          tap_data,
	output logic                      overload,
	output logic                      silence,
	output audio_pkg::chain_s         chain_orders
);

	// ==============================================================
	// Helper functions.
	function automatic logic [17:0] get_word(logic [1:0] f, logic [19:0] sh, logic [17:0] iw);
		unique case (f)
			`FMT_I2S:   get_word = iw;
			`FMT_LSB16: get_word = {sh[15:0], 2'b00};
			`FMT_LSB18: get_word = sh[17:0];
			`FMT_LSB20: get_word = sh[19:2];
		endcase
	endfunction

	function automatic logic in_win(logic [9:0] c, logic [9:0] lo, logic [9:0] hi);
		in_win = (c >= lo) && (c <= hi);
	endfunction

	function automatic logic [16:0] mag(logic signed [17:0] x);
		mag = x[17] ? 17'(-x) : x[16:0];
	endfunction

	function automatic logic signed [17:0] interp(logic signed [17:0] p, logic signed [17:0] c,
			logic [3:0] ph, logic ds);
		logic signed [18:0] d;
		logic signed [23:0] m;
		d = {c[17], c} - {p[17], p};
		m = d * $signed({1'b0, ph});
		m = ds ? (m >>> 3) : (m >>> 4);
		interp = 18'(24'(p) + m);
	endfunction

	function automatic logic signed [17:0] gain(logic signed [17:0] x, logic [7:0] g);
		logic signed [26:0] m;
		m = x * $signed({1'b0, g});
		gain = 18'(m >>> 8);
	endfunction

	function automatic logic [12:0] fade_period(logic [3:0] ft);
		fade_period = 13'(({9'd0, ft} + 13'd1) * ({5'd0, ft, 4'd0} + 13'd1));
	endfunction

	// ==============================================================
	// State and combinational helpers.
	audio_pkg::state_s r_reg, r_next;
	logic        bck_rise, ws_edge, left_start, speed_mode_bit, wr, clr_wr, mapped;
	logic [1:0]  fmt;
	logic [2:0]  eaddr;
	logic [3:0]  widx;
	logic [17:0] word;
	logic [7:0]  geff;
	logic [16:0] othr, sthr;
	logic [17:0] sil_len;
	logic [31:0] rd_mux;
	audio_pkg::stereo_s lin;

	// Edges come only from second-stage synchroniser flops.
	assign bck_rise   = r_reg.bck_s2 & ~r_reg.bck_d;
	assign ws_edge    = r_reg.ws_s2 ^ r_reg.ws_d;
	assign fmt        = r_reg.ext[`EXT_FMT_IDX][3:2];
	assign speed_mode_bit        = r_reg.ext[`EXT_FMT_IDX][`BIT_DSM];
	// I2S starts the left word on a falling select, justified formats on a rising one.
	assign left_start = ws_edge & ((fmt == `FMT_I2S) ? ~r_reg.ws_s2 : r_reg.ws_s2);
	assign word       = get_word(fmt, r_reg.shift, r_reg.i2s_word);
	assign eaddr      = r_reg.main[`IDX_EADDR][2:0];
	assign widx       = paddr[5:2];
	assign mapped     = (paddr <= `STATUS_ADDR) && (paddr[1:0] == 2'b00);
	assign wr         = psel & penable & r_reg.pready & pwrite & ~r_reg.pslverr;
	assign clr_wr     = wr && (paddr <= `MAIN_TOP) && (widx == `IDX_EDATA)
		&& (eaddr == {1'b0, `EXT_FMT_IDX}) && pwdata[`BIT_CLEAR_MEMORY_BIT];
	// Soft mute ramps its own gain; the smaller of the two wins.
	assign geff       = (r_reg.mute_gain < r_reg.cur_vol) ? r_reg.mute_gain : r_reg.cur_vol;
	// Every 3 dB is roughly half a bit, so the threshold halves each two codes.
	assign othr = `OVL_FULL >> (~r_reg.main[`IDX_OVER] >> 1);
	assign sthr = (r_reg.main[`IDX_SIL] == 4'hf) ? 17'd1
		: (`SIL_THR >> r_reg.main[`IDX_SIL][3:1]);
	assign sil_len = 18'(({14'd0, r_reg.main[`IDX_SILT]} + 18'd1) * `SIL_STEP);
	assign lin.left  = interp(r_reg.prev.left, r_reg.cur.left, r_reg.phase, speed_mode_bit);
	assign lin.right = interp(r_reg.prev.right, r_reg.cur.right, r_reg.phase, speed_mode_bit);

	// Read multiplexer; the extended page is visible directly, read only.
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (paddr <= `MAIN_TOP) begin
			rd_mux[3:0] = r_reg.main[widx];
		end else if (paddr < `STATUS_ADDR) begin
			rd_mux[3:0] = r_reg.ext[widx[1:0]];
		end else begin
			rd_mux[15:0] = {r_reg.cur_vol, 2'b00, r_reg.mute_gain == 8'h00, r_reg.sil,
				r_reg.ovl, r_reg.cur_vol != r_reg.tgt_vol, speed_mode_bit, r_reg.lock_st == audio_pkg::LK_LOCKED};
		end
	end

	// ==============================================================
	// Next-state logic for the whole block.
	always_comb begin
		r_next = r_reg;
		// Two-flop synchronisers for the serial pins.
		r_next.bck_s1 = bck_in;
		r_next.bck_s2 = r_reg.bck_s1;
		r_next.bck_d  = r_reg.bck_s2;
		r_next.ws_s1  = ws_in;
		r_next.ws_s2  = r_reg.ws_s1;
		r_next.ws_d   = r_reg.ws_s2;
		r_next.din_s1 = data_in;
		r_next.din_s2 = r_reg.din_s1;

		// APB: answer is prepared in setup, so access needs no wait state.
		r_next.pready  = 1'b0;
		r_next.pslverr = 1'b0;
		if (psel && !penable) begin
			r_next.pready  = 1'b1;
			r_next.pslverr = ~mapped;
			r_next.prdata  = rd_mux;
		end
		// Writes beyond the main page are ignored; reserved nibbles just store.
		if (wr && (paddr <= `MAIN_TOP)) begin
			r_next.main[widx] = pwdata[3:0];
			if (widx == `IDX_EDATA && eaddr[2] == 1'b0) begin
				r_next.ext[eaddr[1:0]] = pwdata[3:0];
			end
		end

		// Serial shifter; a word select edge restarts the bit count.
		if (bck_rise) begin
			r_next.shift = {r_reg.shift[18:0], r_reg.din_s2};
			if (r_reg.bitcnt == `I2S_LAST) begin
				r_next.i2s_word = {r_reg.shift[16:0], r_reg.din_s2};
			end
		end
		if (ws_edge) begin
			r_next.bitcnt = 6'd0;
		end else if (bck_rise && r_reg.bitcnt != 6'h3f) begin
			r_next.bitcnt = 6'(r_reg.bitcnt + 6'd1);
		end
		if (ws_edge && !left_start) begin
			r_next.rx_left = word;
		end

		// Lock tracking on left-channel transitions.
		if (r_reg.lock_cnt != `CNT_MAX) begin
			r_next.lock_cnt = 10'(r_reg.lock_cnt + 10'd1);
		end
		unique case (r_reg.lock_st)
			audio_pkg::LK_LOCKED: begin
				if (left_start) begin
					r_next.lock_cnt = 10'd0;
					if (!in_win(r_reg.lock_cnt, `LOCK_LO, `LOCK_HI)) begin
						r_next.lock_st = audio_pkg::LK_HUNT;
					end
				end else if (r_reg.lock_cnt > `LOCK_HI) begin
					r_next.lock_cnt = 10'd0;
					r_next.lock_st  = audio_pkg::LK_HUNT;
				end
			end
			audio_pkg::LK_HUNT: begin
				// A stray edge re-anchors the count; a missed window starts a new one.
				if (left_start) begin
					r_next.lock_cnt = 10'd0;
					if (in_win(r_reg.lock_cnt, `HUNT_LO, `HUNT_HI)) begin
						r_next.lock_st = audio_pkg::LK_LOCKED;
					end
				end else if (r_reg.lock_cnt > `HUNT_HI) begin
					r_next.lock_cnt = 10'd0;
				end
			end
		endcase

		// A completed pair enters the delay line only while lock holds.
		r_next.smp_new   = 1'b0;
		r_next.os_strobe = 1'b0;
		if (left_start && r_reg.lock_st == audio_pkg::LK_LOCKED
				&& in_win(r_reg.lock_cnt, `LOCK_LO, `LOCK_HI)) begin
			r_next.smp_new   = 1'b1;
			r_next.prev      = r_reg.cur;
			r_next.cur.left  = r_reg.rx_left;
			r_next.cur.right = word;
			r_next.phase     = 4'd0;
			r_next.hold      = 3'd0;
			r_next.tick      = 4'd0;
		end else if (r_reg.tick == (speed_mode_bit ? `TICK_DS : `TICK_NS)) begin
			// Linear interpolation step, each value held six output ticks.
			r_next.tick      = 4'd0;
			r_next.os_strobe = 1'b1;
			r_next.os_out.left  = gain(lin.left, geff);
			r_next.os_out.right = gain(lin.right, geff);
			r_next.tap = r_reg.main[`IDX_MISC][`BIT_ANALYSER_POSITION_BIT] ? r_reg.cur.left
				: gain(lin.left, geff);
			if (r_reg.hold == `HOLD_LAST) begin
				r_next.hold = 3'd0;
				if (r_reg.phase != (speed_mode_bit ? `PH_DS : `PH_NS)) begin
					r_next.phase = 4'(r_reg.phase + 4'd1);
				end
			end else begin
				r_next.hold = 3'(r_reg.hold + 3'd1);
			end
		end else begin
			r_next.tick = 4'(r_reg.tick + 4'd1);
		end
		if (clr_wr) begin
			r_next.prev = '0;
			r_next.cur  = '0;
		end

		// Structure of the half-band chain for the selected speed.
		r_next.chain = speed_mode_bit ? {`ORD1_DS, `ORD2_DS, `ORD3_NONE}
			: {`ORD1_NS, `ORD2_NS, `ORD3_NS};

		// Volume target only moves while the run-fade bit is set.
		if (r_reg.main[`IDX_EADDR][`BIT_RUN]) begin
			r_next.tgt_vol = {r_reg.main[`IDX_VOL_HI], r_reg.main[`IDX_VOL_LO]};
		end
		if (speed_mode_bit) begin
			r_next.cur_vol  = r_reg.tgt_vol;
			r_next.fade_cnt = 13'd0;
		end else if (r_reg.smp_new) begin
			// One code step per period: a full 255-step fade takes the coded time.
			if (r_reg.fade_cnt >= 13'(fade_period(r_reg.main[`IDX_FADE]) - 13'd1)) begin
				r_next.fade_cnt = 13'd0;
				if (r_reg.cur_vol < r_reg.tgt_vol) begin
					r_next.cur_vol = 8'(r_reg.cur_vol + 8'd1);
				end else if (r_reg.cur_vol > r_reg.tgt_vol) begin
					r_next.cur_vol = 8'(r_reg.cur_vol - 8'd1);
				end
			end else begin
				r_next.fade_cnt = 13'(r_reg.fade_cnt + 13'd1);
			end
		end
		if (r_reg.smp_new) begin
			if (r_reg.main[`IDX_MISC][`BIT_MUTE] && r_reg.mute_gain != 8'h00) begin
				r_next.mute_gain = 8'(r_reg.mute_gain - 8'd1);
			end else if (!r_reg.main[`IDX_MISC][`BIT_MUTE] && r_reg.mute_gain != `GAIN_FULL) begin
				r_next.mute_gain = 8'(r_reg.mute_gain + 8'd1);
			end
			// Monitors look at the incoming pair.
			r_next.ovl = (mag(r_reg.cur.left) >= othr) || (mag(r_reg.cur.right) >= othr);
			if ((mag(r_reg.cur.left) < sthr) && (mag(r_reg.cur.right) < sthr)) begin
				if (r_reg.sil_cnt != 18'h3ffff) begin
					r_next.sil_cnt = 18'(r_reg.sil_cnt + 18'd1);
				end
				r_next.sil = (r_reg.sil_cnt >= sil_len);
			end else begin
				r_next.sil_cnt = 18'd0;
				r_next.sil     = 1'b0;
			end
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg           <= '0;
			r_reg.main      <= `MAIN_RESET;
			r_reg.ext       <= `EXT_RESET;
			r_reg.lock_st   <= audio_pkg::LK_HUNT;
			r_reg.mute_gain <= `GAIN_FULL;
			r_reg.chain     <= {`ORD1_NS, `ORD2_NS, `ORD3_NS};
			// Start at the reset volume so a fresh part is not silent for a whole fade.
			r_reg.cur_vol   <= `VOL_RESET;
			r_reg.tgt_vol   <= `VOL_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from state flops.
	assign prdata       = r_reg.prdata;
	assign pready       = r_reg.pready;
	assign pslverr      = r_reg.pslverr;
	assign os_data      = r_reg.os_out;
	assign os_strobe    = r_reg.os_strobe;
	assign lock_ok      = (r_reg.lock_st == audio_pkg::LK_LOCKED);
	assign tap_data     = r_reg.tap;
	assign overload     = r_reg.ovl;
	assign silence      = r_reg.sil;
	assign chain_orders = r_reg.chain;

	// ==============================================================
	// Assertions.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_apb_answer;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("APB answer timing wrong.");

	property p_lock_timeout;
		r_reg.lock_st == audio_pkg::LK_LOCKED && !left_start
			&& r_reg.lock_cnt == 10'(`LOCK_HI + 10'd1)
			|=> !lock_ok && r_reg.lock_cnt == 10'd0;
	endproperty
	a_lock_timeout: assert property (p_lock_timeout) else $error("Late edge kept lock.");

	property p_hunt_repeat;
		!lock_ok && !left_start && r_reg.lock_cnt == 10'(`HUNT_HI + 10'd1)
			|=> r_reg.lock_cnt == 10'd0;
	endproperty
	a_hunt_repeat: assert property (p_hunt_repeat) else $error("Hunt window not restarted.");

	property p_tolerance;
		lock_ok && left_start && r_reg.lock_cnt >= `LOCK_LO && r_reg.lock_cnt <= `LOCK_HI
			|=> lock_ok && r_reg.smp_new;
	endproperty
	a_tolerance: assert property (p_tolerance) else $error("Edge in window dropped lock.");

	property p_no_sample_unlocked;
		r_reg.smp_new |-> $past(lock_ok);
	endproperty
	a_no_sample_unlocked: assert property (p_no_sample_unlocked) else $error("Sample while unlocked.");

	property p_clear;
		clr_wr |=> r_reg.cur == '0 && r_reg.prev == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("Delay line not flushed.");

	property p_mute_ramp;
		r_reg.main[`IDX_MISC][`BIT_MUTE] && r_reg.smp_new && r_reg.mute_gain != 8'h00
			|=> r_reg.mute_gain == 8'($past(r_reg.mute_gain) - 8'd1);
	endproperty
	a_mute_ramp: assert property (p_mute_ramp) else $error("Mute ramp did not step.");

	property p_ds_volume;
		speed_mode_bit && $stable(speed_mode_bit) |-> r_reg.cur_vol == $past(r_reg.tgt_vol);
	endproperty
	a_ds_volume: assert property (p_ds_volume) else $error("Double speed volume delayed.");

	property p_run_fade;
		r_reg.main[`IDX_EADDR][`BIT_RUN]
			|=> r_reg.tgt_vol == {$past(r_reg.main[`IDX_VOL_HI]), $past(r_reg.main[`IDX_VOL_LO])};
	endproperty
	a_run_fade: assert property (p_run_fade) else $error("Run fade did not load target.");

endmodule // audio_input_oversampling_path

// ### include/audio_consts.svh
// Constants for the audio input and oversampling path.
`ifndef AUDIO_CONSTS_SVH
`define AUDIO_CONSTS_SVH
// ==============================================================
// Register map, byte addresses.
`define MAIN_TOP      8'h3c
`define EXT_BASE      8'h40
`define STATUS_ADDR   8'h50
`define IDX_VOL_LO    4'h2
`define IDX_VOL_HI    4'h3
`define IDX_FADE      4'h4
`define IDX_OVER      4'h6
`define IDX_SIL       4'h7
`define IDX_SILT      4'h8
`define IDX_MISC      4'h9
`define IDX_EDATA     4'he
`define IDX_EADDR     4'hf
`define EXT_FMT_IDX   2'd0
`define BIT_MUTE      3
`define BIT_ANALYSER_POSITION_BIT      0
`define BIT_RUN       3
`define BIT_DSM       1
`define BIT_CLEAR_MEMORY_BIT      0
`define MAIN_RESET    64'hff0067000f00efff
`define EXT_RESET     16'h0320
// ==============================================================
// Input formats.
`define FMT_I2S       2'b00
`define FMT_LSB16     2'b01
`define FMT_LSB18     2'b10
`define FMT_LSB20     2'b11
`define I2S_LAST      6'd18
// ==============================================================
// Word-select lock timing in system clocks.
`define LOCK_LO       10'd496
`define LOCK_HI       10'd527
`define HUNT_LO       10'd504
`define HUNT_HI       10'd519
`define CNT_MAX       10'h3ff
// ==============================================================
// Oversampling pacing and filter structure.
`define TICK_NS       4'd4
`define TICK_DS       4'd9
`define PH_NS         4'd15
`define PH_DS         4'd7
`define HOLD_LAST     3'd5
`define ORD1_NS       7'd75
`define ORD2_NS       7'd11
`define ORD3_NS       7'd7
`define ORD1_DS       7'd51
`define ORD2_DS       7'd7
`define ORD3_NONE     7'd0
// ==============================================================
// Level monitors.
`define SIL_STEP      18'd8820
`define SIL_THR       17'h00200
`define OVL_FULL      17'h1ffff
`define GAIN_FULL     8'hff
`define VOL_RESET     8'hef
`endif

// ### include/audio_pkg.sv
// Types shared by the audio input and oversampling path.
package audio_pkg;
	typedef enum logic [0:0] {LK_HUNT = 1'b0, LK_LOCKED = 1'b1} lock_e;
	typedef struct packed {
		logic signed [17:0] left;
		logic signed [17:0] right;
	} stereo_s;
	typedef struct packed {
		logic [6:0] ord1;
		logic [6:0] ord2;
		logic [6:0] ord3;
	} chain_s;
	typedef struct packed {
		logic [15:0][3:0] main;
		logic [3:0][3:0]  ext;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
		logic             bck_s1, bck_s2, bck_d;
		logic             ws_s1, ws_s2, ws_d;
		logic             din_s1, din_s2;
		logic [19:0]      shift;
		logic [5:0]       bitcnt;
		logic [17:0]      i2s_word;
		logic [17:0]      rx_left;
		lock_e            lock_st;
		logic [9:0]       lock_cnt;
		logic             smp_new;
		stereo_s          prev;
		stereo_s          cur;
		logic [3:0]       tick;
		logic [3:0]       phase;
		logic [2:0]       hold;
		stereo_s          os_out;
		logic             os_strobe;
		logic [7:0]       cur_vol;
		logic [7:0]       tgt_vol;
		logic [12:0]      fade_cnt;
		logic [7:0]       mute_gain;
		logic [17:0]      tap;
		logic             ovl;
		logic             sil;
		logic [17:0]      sil_cnt;
		chain_s           chain;
	} state_s;
endpackage

// ### testbench/audio_source_model.sv
// Behavioural serial audio source sending stereo words in the inter-IC sound format.
`timescale 1ns/1ps

module audio_source_model (
	output logic             bck,
	output logic             ws,
	output logic             sd,
	input  wire logic [19:0] left_word,
	input  wire logic [19:0] right_word,
	input  wire logic [3:0]  extra_slots
);
	// ==============================================================
	// Channel sender
	// Slot 0 is the delay bit, then the word goes out MSB first. Unused slots toggle, so the
	// receiver cannot get a match from a stale level.
	task automatic send_half(input logic sel, input logic [19:0] word, input int slots);
		for (int k = 0; k < slots; k++) begin
			ws = sel;
			sd = (k >= 1 && k <= 20) ? word[20 - k] : ~sd;
			#100 bck = 1'b1;
			#100 bck = 1'b0;
		end
	endtask

	// ==============================================================
	// Frame generator
	// Both halves carry 32 slots, so word select stays symmetric unless the bench asks for
	// extra slots to disturb the frame length on purpose.
	initial begin
		bck = 1'b0;
		ws = 1'b1;
		sd = 1'b0;
		#37;
		forever begin
			send_half(1'b0, left_word, 32);
			send_half(1'b1, right_word, 32 + int'(extra_slots));
		end
	end
endmodule // audio_source_model

// ### testbench/audio_input_oversampling_path_bench.sv
// Self-checking bench for the audio input and oversampling path.
`timescale 1ns/1ps
`include "audio_consts.svh"

module audio_input_oversampling_path_bench;
	localparam logic [63:0] main_rst = `MAIN_RESET;
	localparam logic [15:0] ext_rst  = `EXT_RESET;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0;
	logic [31:0]        prdata;
	logic               pready, pslverr, bck, ws, sd;
	audio_pkg::stereo_s os_data;
	logic               os_strobe, lock_ok, overload, silence;
	logic [17:0]        tap_data, keep;
	audio_pkg::chain_s  chain_orders;
	logic [19:0]        lw = 20'h12345;
	logic [19:0]        rw = 20'hedcba;
	logic [3:0]         extra = 4'h0;
	int                 fail_count = 0;
	int                 checks = 0;
	int                 g, lows, strobes;

	// ==============================================================
	// Clock and instances
	always #12.5 pclk = ~pclk;

	audio_input_oversampling_path audio_input_oversampling_path_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bck_in(bck), .ws_in(ws), .data_in(sd), .os_data(os_data), .os_strobe(os_strobe),
		.lock_ok(lock_ok), .tap_data(tap_data), .overload(overload), .silence(silence),
		.chain_orders(chain_orders));

	audio_source_model audio_source_model_inst (
		.bck(bck), .ws(ws), .sd(sd), .left_word(lw), .right_word(rw), .extra_slots(extra));

	// ==============================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task report_and_stop;
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One APB transfer; the request holds until pready is seen high at a rising edge.
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] mask, input logic [31:0] exp, input logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		check("pready", n < 20, 1);
		check("read data", prdata & mask, exp);
		check("slave error", pslverr, err);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic frames(input int k);
		repeat (k * 512) @(posedge pclk);
		#1;
	endtask

	// Counts cycles without lock and strobes seen over a span.
	task automatic watch(input int cycles, output int lo, output int st);
		lo = 0;
		st = 0;
		repeat (cycles) begin
			@(posedge pclk);
			lo += (lock_ok !== 1'b1);
			st += (os_strobe === 1'b1);
		end
	endtask

	// Smallest spacing between strobes, measured from a strobe onward.
	task automatic min_gap(output int gp);
		int n;
		gp = 999;
		repeat (5) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (os_strobe !== 1'b1 && n < 2000);
			if (n < gp && gp != 999 || gp == 999) gp = (gp == 999) ? 998 : n;
		end
	endtask

	task automatic wait_lock(output int st);
		int n;
		n = 0;
		st = 0;
		while (lock_ok !== 1'b1 && n < 20 * 512) begin
			@(posedge pclk);
			n++;
			st += (os_data !== '0);
		end
		#1;
	endtask

	// ==============================================================
	// Watchdog: the whole sequence needs well under 1 ms.
	initial begin
		#1_000_000;
		fail_count++;
		report_and_stop;
	end

	// ==============================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check("chain", chain_orders, {11'h0, `ORD1_NS, `ORD2_NS, `ORD3_NS});
		for (int i = 0; i < 16; i++) acc(0, 8'(i * 4), 0, 32'hf, 32'(main_rst[i*4+:4]), 0);
		for (int i = 0; i < 4; i++) acc(0, 8'(64 + i * 4), 0, 32'hf, 32'(ext_rst[i*4+:4]), 0);
		for (int i = 0; i < 14; i++) begin
			acc(1, 8'(i * 4), 32'(i[3:0] ^ 4'ha), 0, 0, 0);
			acc(0, 8'(i * 4), 0, 32'hffffffff, 32'(i[3:0] ^ 4'ha), 0);
		end
		acc(1, 8'h08, 32'hf, 0, 0, 0);
		acc(1, 8'h0c, 32'he, 0, 0, 0);
		acc(1, 8'h3c, 32'h8, 0, 0, 0);
		acc(0, 8'h3c, 0, 32'hf, 32'h8, 0);
		acc(0, 8'h54, 0, 0, 0, 1);
		acc(0, 8'h01, 0, 0, 0, 1);
		acc(1, 8'h40, 32'hf, 0, 0, 0);
		acc(0, 8'h40, 0, 32'hf, 32'h0, 0);
		wait_lock(strobes);
		check("samples before lock", strobes, 0);
		check("lock", lock_ok, 1);
		acc(0, 8'h50, 0, 32'h3, 32'h1, 0);
		min_gap(g);
		check("normal strobe gap", g, 32'(`TICK_NS) + 1);
		frames(3);
		keep = os_data.left;
		check("left nonzero", os_data.left != 18'h0, 1);
		// Analyser taps ahead of tone control here, so it shows the raw left word.
		check("tap", tap_data, 32'(lw[19:2]));
		// A loud steady tone is neither overloaded at this level nor silent.
		check("overload", overload, 0);
		check("silence", silence, 0);
		lw = 20'h12346;
		frames(3);
		check("left ignores low bits", os_data.left, keep);
		extra = 4'h1;
		watch(512, lows, strobes);
		extra = 4'h0;
		watch(1200, g, strobes);
		check("lock within tolerance", lows + g, 0);
		extra = 4'h8;
		watch(512, lows, strobes);
		extra = 4'h0;
		watch(1200, g, strobes);
		check("lock lost", lows + g != 0, 1);
		wait_lock(strobes);
		check("lock regained", lock_ok, 1);
		acc(1, 8'h38, 32'h2, 0, 0, 0);
		acc(0, 8'h40, 0, 32'hf, 32'h2, 0);
		check("chain", chain_orders, {11'h0, `ORD1_DS, `ORD2_DS, `ORD3_NONE});
		min_gap(g);
		check("double strobe gap", g, 32'(`TICK_DS) + 1);
		acc(1, 8'h3c, 32'h0, 0, 0, 0);
		acc(1, 8'h08, 32'h0, 0, 0, 0);
		acc(1, 8'h0c, 32'h0, 0, 0, 0);
		frames(3);
		check("held volume", os_data.left != 18'h0, 1);
		acc(1, 8'h3c, 32'h8, 0, 0, 0);
		frames(3);
		check("zero volume", os_data, 36'h0);
		for (int f = 0; f < 4; f++) begin
			acc(1, 8'h38, 32'(f << 2), 0, 0, 0);
			acc(0, 8'h40, 0, 32'hf, 32'(f << 2), 0);
		end
		acc(1, 8'h38, 32'h1, 0, 0, 0);
		acc(0, 8'h40, 0, 32'hf, 32'h1, 0);
		#1;
		check("chain", chain_orders, {11'h0, `ORD1_NS, `ORD2_NS, `ORD3_NS});
		report_and_stop;
	end
endmodule // audio_input_oversampling_path_bench
